// File: host_cpu_port_irq_merge_bench.sv
// bench joining master and device ends, driven through the software port
// assumes default latency; expectations come from bench constants only
`timescale 1ns/1ps
module host_cpu_port_irq_merge_bench;
    import hostport_pkg::*;
    logic              clk_i;
    logic              reset_i;
    logic [3:0]        sw_addr_i;
    logic [DATA_W-1:0] sw_wdata_i;
    logic              sw_wr_i;
    logic              sw_rd_i;
    logic [DATA_W-1:0] sw_rdata_o;
    logic              sw_irq_o;
    logic [2:0]        link_irq_set_i;
    logic              eth_rx_irq_i;
    logic              eth_tx_irq_i;
    logic              hdlc_rx_irq_i;
    logic              hdlc_tx_irq_i;
    logic [DATA_W-1:0] rd;
    logic [DATA_W-1:0] exp;
    logic [3:0]        src;
    int                err_count;
    int                checked;
    hostport_if hp ();
    hostport_device hostport_device_i (.clk_i, .reset_i, .port(hp), .link_irq_set_i,
        .eth_rx_irq_i, .eth_tx_irq_i, .hdlc_rx_irq_i, .hdlc_tx_irq_i);
    hostport_master hostport_master_i (.clk_i, .reset_i, .sw_addr_i, .sw_wdata_i,
        .sw_wr_i, .sw_rd_i, .sw_rdata_o, .sw_irq_o, .port(hp));
    hostport_props hostport_props_i (.clk_i, .reset_i, .address(hp.address),
        .write(hp.write), .read(hp.read), .writedata(hp.writedata), .readdata(hp.readdata),
        .waitrequest(hp.waitrequest), .irq(hp.irq), .irq_vector(hp.irq_vector),
        .link_irq_set_i, .eth_rx_irq_i, .eth_tx_irq_i, .hdlc_rx_irq_i, .hdlc_tx_irq_i);
    task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] s);
        checked++;
        if (s !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, e, s);
        end
    endtask
    // expected vector word from the link bits and {eth_rx, eth_tx, hdlc_rx, hdlc_tx}
    function automatic logic [31:0] vec_model(input logic [2:0] link, input logic [3:0] s);
        logic [31:0] v;
        v              = ZERO_WORD;
        v[IRQ_LINK]    = |link;
        v[IRQ_ETH_RX]  = s[3];
        v[IRQ_ETH_TX]  = s[2];
        v[IRQ_HDLC_RX] = s[1];
        v[IRQ_HDLC_TX] = s[0];
        return v;
    endfunction
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic sw_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        sw_addr_i <= a;
        sw_wdata_i <= d;
        sw_wr_i <= 1'b1;
        @(posedge clk_i);
        sw_wr_i <= 1'b0;
    endtask
    task automatic sw_read(input logic [3:0] a, output logic [31:0] q);
        @(posedge clk_i);
        sw_addr_i <= a;
        sw_rd_i <= 1'b1;
        @(posedge clk_i);
        sw_rd_i <= 1'b0;
        #1 q = sw_rdata_o;
    endtask
    // one device access ordered through the controller, polled on its done event
    task automatic dev(input logic [1:0] c, input logic [15:0] ba, input logic [31:0] d,
        output logic [31:0] q);
        int n;
        n = 0;
        sw_write(CR_ADDR, {16'h0, ba});
        sw_write(CR_WDATA, d);
        sw_write(CR_IRQ_ST, 32'h1);
        sw_write(CR_CMD, {30'h0, c});
        do begin
            sw_read(CR_IRQ_ST, q);
            n++;
        end while (q[EV_DONE] !== 1'b1 && n < 50);
        cmp("done event", 32'h1, 32'(q[EV_DONE]));
        sw_read(CR_RDATA, q);
    endtask
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    initial begin
        #2000000;
        err_count++;
        conclude();
    end
    initial begin
        {err_count, checked} = '0;
        {reset_i, sw_addr_i, sw_wdata_i, sw_wr_i, sw_rd_i, link_irq_set_i} = '0;
        {eth_rx_irq_i, eth_tx_irq_i, hdlc_rx_irq_i, hdlc_tx_irq_i} = 4'h0;
        reset_i = 1'b1;
        void'($urandom(81927));
        repeat (4) @(posedge clk_i);
        reset_i <= 1'b0;
        // low byte-address bits differ between write and read and must be dropped
        for (int i = 0; i < 4; i++) begin
            exp = $urandom();
            dev(2'b01, {OFF_SCRATCH, 2'(i)}, exp, rd);
            dev(2'b10, {OFF_SCRATCH, 2'(3 - i)}, 32'h0, rd);
            cmp("scratch", exp, rd);
            sw_read(CR_ADDR, rd);
            cmp("byte address", {16'h0, OFF_SCRATCH, 2'b00}, rd);
        end
        dev(2'b10, 16'hfffc, 32'h0, rd);
        cmp("unmapped", 32'h0, rd);
        // both command bits at once is refused and leaves the controller idle
        sw_write(CR_CMD, 32'h3);
        sw_read(CR_STATUS, rd);
        cmp("refused command", 32'h0, rd);
        for (int i = 0; i < 8; i++) begin
            src = (i < 4) ? 4'(1 << i) : 4'($urandom_range(15));
            exp = vec_model(3'h0, src);
            @(posedge clk_i);
            {eth_rx_irq_i, eth_tx_irq_i, hdlc_rx_irq_i, hdlc_tx_irq_i} <= src;
            dev(2'b10, {OFF_IRQ_VECTOR, 2'b00}, 32'h0, rd);
            cmp("device vector", exp, rd);
            sw_read(CR_VECTOR, rd);
            cmp("vector", exp, rd);
        end
        @(posedge clk_i);
        {eth_rx_irq_i, eth_tx_irq_i, hdlc_rx_irq_i, hdlc_tx_irq_i} <= 4'h0;
        link_irq_set_i <= 3'h5;
        @(posedge clk_i);
        link_irq_set_i <= 3'h0;
        dev(2'b10, {OFF_LINK_INTR, 2'b00}, 32'h0, rd);
        cmp("link", 32'h5, rd);
        dev(2'b01, {OFF_LINK_INTR, 2'b00}, 32'h4, rd);
        sw_read(CR_VECTOR, rd);
        cmp("vector", vec_model(3'h1, 4'h0), rd);
        dev(2'b01, {OFF_LINK_INTR, 2'b00}, 32'h1, rd);
        sw_read(CR_VECTOR, rd);
        cmp("vector", vec_model(3'h0, 4'h0), rd);
        // one-cycle reset in mid-run, released on an edge, must clear the scratch word
        @(posedge clk_i);
        reset_i <= 1'b1;
        @(posedge clk_i);
        reset_i <= 1'b0;
        dev(2'b10, {OFF_SCRATCH, 2'b00}, 32'h0, rd);
        cmp("scratch after reset", ZERO_WORD, rd);
        // done event masked in, then masked out; device irq event then raised and cleared
        sw_write(CR_IRQ_ST, 32'h3);
        sw_write(CR_IRQ_MSK, 32'h1);
        sw_read(CR_IRQ_MSK, rd);
        cmp("mask", 32'h1, rd);
        dev(2'b10, {OFF_SCRATCH, 2'b00}, 32'h0, rd);
        cmp("irq", 32'h1, 32'(sw_irq_o));
        sw_write(CR_IRQ_MSK, 32'h2);
        repeat (2) @(posedge clk_i);
        #1 cmp("irq", 32'h0, 32'(sw_irq_o));
        @(posedge clk_i);
        hdlc_tx_irq_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        #1 cmp("irq", 32'h1, 32'(sw_irq_o));
        sw_write(CR_IRQ_ST, 32'h3);
        repeat (2) @(posedge clk_i);
        #1 cmp("irq", 32'h0, 32'(sw_irq_o));
        conclude();
    end
endmodule // host_cpu_port_irq_merge_bench

// File: hostport_device.sv
// device end: word-addressed register port with wait-request and irq merge
// assumes the master keeps its request steady until wait-request falls
`timescale 1ns/1ps
module hostport_device
    import hostport_pkg::*;
#(
    parameter int LATENCY = ACCESS_CYCLES
) (
    // clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  reset_i,
    // host port
    hostport_if.device                 port,
    // interrupt sources
    input  wire logic [LINK_IRQ_W-1:0] link_irq_set_i,
    input  wire logic                  eth_rx_irq_i,
    input  wire logic                  eth_tx_irq_i,
    input  wire logic                  hdlc_rx_irq_i,
    input  wire logic                  hdlc_tx_irq_i
);
    // the wait counter is four bits wide, so longer latencies cannot be served
    if (LATENCY < 1 || LATENCY > 15) begin : g_bad_latency
        $error("LATENCY out of range");
    end

    typedef enum logic [1:0] {IDLE, BUSY, DONE} dev_state_t;

    dev_state_t        state_ff, nxt_state;
    logic [3:0]        cnt_ff, nxt_cnt;
    logic [DATA_W-1:0] rdata_ff, nxt_rdata;
    logic              wait_ff, nxt_wait;
    logic [LINK_IRQ_W-1:0] link_intr_ff, nxt_link_intr;
    logic [DATA_W-1:0] scratch_ff, nxt_scratch;
    logic [IRQ_W-1:0]  vec_ff, nxt_vec;
    logic              irq_ff, nxt_irq;
    logic              req;

    assign req = port.read | port.write;

    always_comb begin
        nxt_state     = state_ff;
        nxt_cnt       = cnt_ff;
        nxt_rdata     = rdata_ff;
        nxt_wait      = wait_ff;
        nxt_scratch   = scratch_ff;
        // set wins over a write-one clear
        nxt_link_intr = link_intr_ff | link_irq_set_i;
        unique case (state_ff)
            IDLE: begin
                // wait stays high while idle so a new request is held off
                nxt_wait = 1'b1;
                if (req) begin
                    nxt_state = BUSY;
                    nxt_cnt   = 4'(LATENCY - 1);
                end
            end
            BUSY: begin
                if (cnt_ff == 4'h0) begin
                    if (port.write) begin
                        unique case (port.address)
                            OFF_LINK_INTR: nxt_link_intr = (link_intr_ff
                                & ~port.writedata[LINK_IRQ_W-1:0]) | link_irq_set_i;
                            OFF_SCRATCH:   nxt_scratch = port.writedata;
                            default:       nxt_scratch = scratch_ff;
                        endcase
                    end
                    unique case (port.address)
                        OFF_LINK_INTR:  nxt_rdata = {{(DATA_W-LINK_IRQ_W){1'b0}}, link_intr_ff};
                        OFF_IRQ_VECTOR: nxt_rdata = {{(DATA_W-IRQ_W){1'b0}}, vec_ff};
                        OFF_SCRATCH:    nxt_rdata = scratch_ff;
                        default:        nxt_rdata = ZERO_WORD;
                    endcase
                    nxt_wait  = 1'b0;
                    nxt_state = DONE;
                end else begin
                    nxt_cnt = cnt_ff - 4'h1;
                end
            end
            DONE: begin
                nxt_wait  = 1'b1;
                nxt_state = IDLE;
            end
            default: nxt_state = IDLE;
        endcase
        nxt_vec[IRQ_LINK]    = |link_intr_ff;
        nxt_vec[IRQ_ETH_RX]  = eth_rx_irq_i;
        nxt_vec[IRQ_ETH_TX]  = eth_tx_irq_i;
        nxt_vec[IRQ_HDLC_RX] = hdlc_rx_irq_i;
        nxt_vec[IRQ_HDLC_TX] = hdlc_tx_irq_i;
        nxt_irq = |nxt_vec;
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_ff     <= IDLE;
            cnt_ff       <= 4'h0;
            rdata_ff     <= ZERO_WORD;
            wait_ff      <= 1'b1;
            link_intr_ff <= '0;
            scratch_ff   <= ZERO_WORD;
            vec_ff       <= '0;
            irq_ff       <= 1'b0;
        end else begin
            state_ff     <= nxt_state;
            cnt_ff       <= nxt_cnt;
            rdata_ff     <= nxt_rdata;
            wait_ff      <= nxt_wait;
            link_intr_ff <= nxt_link_intr;
            scratch_ff   <= nxt_scratch;
            vec_ff       <= nxt_vec;
            irq_ff       <= nxt_irq;
        end
    end

    assign port.readdata    = rdata_ff;
    assign port.waitrequest = wait_ff;
    assign port.irq_vector  = vec_ff;
    assign port.irq         = irq_ff;
endmodule // hostport_device

// File: hostport_if.sv
// host port wires between the bus master and the device
// assumes both ends share clk and reset
`timescale 1ns/1ps
interface hostport_if;
    import hostport_pkg::*;
    logic [ADDR_W-1:0] address;
    logic              write;
    logic              read;
    logic [DATA_W-1:0] writedata;
    logic [DATA_W-1:0] readdata;
    logic              waitrequest;
    logic              irq;
    logic [IRQ_W-1:0]  irq_vector;
    modport device (input address, write, read, writedata,
                    output readdata, waitrequest, irq, irq_vector);
    modport master (output address, write, read, writedata,
                    input readdata, waitrequest, irq, irq_vector);
endinterface

// File: hostport_master.sv
// master end: software orders accesses through its own registers
// assumes software strobes are one cycle and on this clock
//
// Strobed register access and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module hostport_master
    import hostport_pkg::*;
(
    // clock and reset
    input  wire logic              clk_i,
    input  wire logic              reset_i,
    // software port
    input  wire logic [3:0]        sw_addr_i,
    input  wire logic [DATA_W-1:0] sw_wdata_i,
    input  wire logic              sw_wr_i,
    input  wire logic              sw_rd_i,
    output logic      [DATA_W-1:0] sw_rdata_o,
    output logic                   sw_irq_o,
    // device side
    hostport_if.master             port
);
    typedef enum logic [1:0] {IDLE, WAIT_LOW, HOLD} mst_state_t;

    mst_state_t        state_ff, nxt_state;
    logic [ADDR_W-1:0] addr_ff, nxt_addr;
    logic [DATA_W-1:0] wdata_ff, nxt_wdata;
    logic              wr_ff, nxt_wr, rd_ff, nxt_rd;
    logic [DATA_W-1:0] rdata_ff, nxt_rdata;
    logic [EV_W-1:0]   ev_ff, nxt_ev, msk_ff, nxt_msk;
    logic [DATA_W-1:0] swr_ff, nxt_swr;
    logic              irq_ff, nxt_irq, dirq_ff;
    logic [EV_W-1:0]   ev_set;

    always_comb begin
        nxt_state = state_ff;
        nxt_addr  = addr_ff;
        nxt_wdata = wdata_ff;
        nxt_wr    = wr_ff;
        nxt_rd    = rd_ff;
        nxt_rdata = rdata_ff;
        nxt_msk   = msk_ff;
        ev_set    = '0;
        ev_set[EV_IRQ] = port.irq & ~dirq_ff;
        unique case (state_ff)
            IDLE: begin
                if (sw_wr_i && sw_addr_i == CR_CMD &&
                    (sw_wdata_i[CMD_WRITE] ^ sw_wdata_i[CMD_READ])) begin
                    nxt_wr    = sw_wdata_i[CMD_WRITE];
                    nxt_rd    = sw_wdata_i[CMD_READ];
                    nxt_state = WAIT_LOW;
                end
            end
            WAIT_LOW: begin
                // hold request until wait-request releases
                if (!port.waitrequest) begin
                    nxt_rdata = port.readdata;
                    nxt_wr    = 1'b0;
                    nxt_rd    = 1'b0;
                    ev_set[EV_DONE] = 1'b1;
                    nxt_state = HOLD;
                end
            end
            HOLD: nxt_state = IDLE;
            default: nxt_state = IDLE;
        endcase
        if (sw_wr_i && state_ff == IDLE) begin
            if (sw_addr_i == CR_ADDR) nxt_addr = sw_wdata_i[ADDR_W+1:2];
            if (sw_addr_i == CR_WDATA) nxt_wdata = sw_wdata_i;
        end
        if (sw_wr_i && sw_addr_i == CR_IRQ_MSK) nxt_msk = sw_wdata_i[EV_W-1:0];
        nxt_ev = ev_ff;
        if (sw_wr_i && sw_addr_i == CR_IRQ_ST) nxt_ev = ev_ff & ~sw_wdata_i[EV_W-1:0];
        nxt_ev = nxt_ev | ev_set;
        unique case (sw_addr_i)
            CR_ADDR:    nxt_swr = {16'h0000, addr_ff, 2'b00};
            CR_WDATA:   nxt_swr = wdata_ff;
            CR_CMD:     nxt_swr = {30'h0, rd_ff, wr_ff};
            CR_STATUS:  nxt_swr = {31'h0, state_ff != IDLE};
            CR_RDATA:   nxt_swr = rdata_ff;
            CR_IRQ_ST:  nxt_swr = {30'h0, ev_ff};
            CR_IRQ_MSK: nxt_swr = {30'h0, msk_ff};
            CR_VECTOR:  nxt_swr = {27'h0, port.irq_vector};
            default:    nxt_swr = ZERO_WORD;
        endcase
        if (!sw_rd_i) nxt_swr = ZERO_WORD;
        nxt_irq = |(nxt_ev & nxt_msk);
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_ff <= IDLE;
            addr_ff  <= '0;
            wdata_ff <= ZERO_WORD;
            wr_ff    <= 1'b0;
            rd_ff    <= 1'b0;
            rdata_ff <= ZERO_WORD;
            ev_ff    <= '0;
            msk_ff   <= '0;
            swr_ff   <= ZERO_WORD;
            irq_ff   <= 1'b0;
            dirq_ff  <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            addr_ff  <= nxt_addr;
            wdata_ff <= nxt_wdata;
            wr_ff    <= nxt_wr;
            rd_ff    <= nxt_rd;
            rdata_ff <= nxt_rdata;
            ev_ff    <= nxt_ev;
            msk_ff   <= nxt_msk;
            swr_ff   <= nxt_swr;
            irq_ff   <= nxt_irq;
            dirq_ff  <= port.irq;
        end
    end

    assign port.address   = addr_ff;
    assign port.writedata = wdata_ff;
    assign port.write     = wr_ff;
    assign port.read      = rd_ff;
    assign sw_rdata_o     = swr_ff;
    assign sw_irq_o       = irq_ff;
endmodule // hostport_master

// File: hostport_pkg.sv
// shared constants for the host register port and interrupt merge
// assumes a single host clock at 10 MHz and a synchronous active-high reset
package hostport_pkg;
    localparam int ADDR_W      = 14;
    localparam int DATA_W      = 32;
    localparam int IRQ_W       = 5;
    localparam int LINK_IRQ_W  = 3;
    // interrupt vector positions
    localparam int IRQ_LINK    = 4;
    localparam int IRQ_ETH_RX  = 3;
    localparam int IRQ_ETH_TX  = 2;
    localparam int IRQ_HDLC_RX = 1;
    localparam int IRQ_HDLC_TX = 0;
    // device word offsets
    localparam logic [ADDR_W-1:0] OFF_LINK_INTR  = 14'h0000;
    localparam logic [ADDR_W-1:0] OFF_IRQ_VECTOR = 14'h0001;
    localparam logic [ADDR_W-1:0] OFF_SCRATCH    = 14'h0002;
    // controller register offsets (software side)
    localparam logic [3:0] CR_ADDR    = 4'h0;
    localparam logic [3:0] CR_WDATA   = 4'h1;
    localparam logic [3:0] CR_CMD     = 4'h2;
    localparam logic [3:0] CR_STATUS  = 4'h3;
    localparam logic [3:0] CR_RDATA   = 4'h4;
    localparam logic [3:0] CR_IRQ_ST  = 4'h5;
    localparam logic [3:0] CR_IRQ_MSK = 4'h6;
    localparam logic [3:0] CR_VECTOR  = 4'h7;
    // command bits
    localparam int CMD_WRITE = 0;
    localparam int CMD_READ  = 1;
    // controller status-event bits
    localparam int EV_DONE = 0;
    localparam int EV_IRQ  = 1;
    localparam int EV_W    = 2;
    // device access latency in host cycles, wait-request held one cycle longer from the request
    localparam int ACCESS_CYCLES = 2;
    localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;
endpackage

// File: hostport_props.sv
// assertions on the host port wires between master and device ends
// assumes one clock, synchronous active-high reset, default latency
`timescale 1ns/1ps
module hostport_props (
    // clock and reset
    input wire logic        clk_i,
    input wire logic        reset_i,
    // host port
    input wire logic [13:0] address,
    input wire logic        write,
    input wire logic        read,
    input wire logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    input wire logic        irq,
    input wire logic [4:0]  irq_vector,
    // interrupt sources
    input wire logic [2:0]  link_irq_set_i,
    input wire logic        eth_rx_irq_i,
    input wire logic        eth_tx_irq_i,
    input wire logic        hdlc_rx_irq_i,
    input wire logic        hdlc_tx_irq_i
);
    default clocking dcb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);
    chk_irq_merge: assert property (irq == |irq_vector)
        else $error("merged irq differs from vector");
    chk_link_bit: assert property (!$past(reset_i) && !$past(reset_i, 2)
        && $past(link_irq_set_i, 2) != 3'h0 |-> irq_vector[4])
        else $error("link event missing from vector");
    chk_eth_bits: assert property (!$past(reset_i) |-> irq_vector[3] == $past(eth_rx_irq_i)
        && irq_vector[2] == $past(eth_tx_irq_i)) else $error("ethernet vector bits wrong");
    chk_hdlc_bits: assert property (!$past(reset_i) |-> irq_vector[1] == $past(hdlc_rx_irq_i)
        && irq_vector[0] == $past(hdlc_tx_irq_i)) else $error("hdlc vector bits wrong");
    chk_wait_latency: assert property ($rose(read || write) |-> waitrequest[*3] ##1 !waitrequest)
        else $error("wait-request released at wrong cycle");
    chk_wait_pulse: assert property (!waitrequest |=> waitrequest)
        else $error("wait-request low too long");
    chk_wait_idle: assert property (!(read || write) |-> waitrequest)
        else $error("wait-request low without request");
    chk_req_hold: assert property ((read || write) && waitrequest
        |=> (read || write) && $stable(address) && $stable(writedata))
        else $error("request changed before completion");
    chk_req_drop: assert property (!waitrequest |=> !(read || write))
        else $error("request kept after completion");
    // a reset clears read data, so the edge after its release is left out
    chk_rdata_hold: assert property (!$past(reset_i) && waitrequest && $past(waitrequest)
        |-> $stable(readdata)) else $error("read data changed outside completion");
    cover property (read && !waitrequest);
    cover property (write && !waitrequest);
    cover property ($rose(irq));
endmodule // hostport_props
